// File: logic/adc_seq_pkg.sv
package adc_seq_pkg;

    localparam int STACK_DEPTH = 24;
    localparam int LAYER_W = 5;
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 16;

    // Register index map; byte address is four times the index
    localparam logic [6:0] STACK_FIRST_IDX = 7'h28;
    localparam logic [6:0] STACK_LAST_IDX = 7'h3F;
    localparam logic [6:0] CTRL_IDX = 7'h40;
    localparam logic [6:0] STATUS_IDX = 7'h41;

    // Stack layer word fields
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 9;
    localparam int END_BIT = 8;
    localparam int BSEL_MSB = 7;
    localparam int BSEL_LSB = 4;
    localparam int ASEL_MSB = 3;
    localparam int ASEL_LSB = 0;

    // Control register fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_STAT_BIT = 1;
    localparam int CTRL_CRC_BIT = 2;
    localparam int CTRL_LAYER_LSB = 8;
    localparam int CTRL_LAYER_MSB = 12;

    // Channel select codes
    localparam logic [3:0] SEL_SUPPLY = 4'h8;
    localparam logic [3:0] SEL_REGULATOR = 4'h9;
    localparam logic [3:0] SEL_SELF_TEST = 4'hB;

    localparam logic [15:0] SELF_TEST_A = 16'hAAAA;
    localparam logic [15:0] SELF_TEST_B = 16'h5555;

    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [LAYER_W-1:0] LAYER_LAST = 5'h17;
    localparam logic [LAYER_W-1:0] LAYER_FIRST = 5'h00;

    typedef struct packed {
        logic end_flag;
        logic [3:0] b_sel;
        logic [3:0] a_sel;
    } layer_t;

    localparam layer_t LAYER_RESET = '{end_flag: 1'b0, b_sel: 4'h0, a_sel: 4'h0};

    typedef struct packed {
        logic [9:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [3:0] a_sel;
        logic [3:0] b_sel;
        logic start;
    } conv_ctrl_t;

    typedef struct packed {
        logic done;
        logic [15:0] a_code;
        logic [15:0] b_code;
    } conv_result_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CONV = 3'b001,
        ST_WAIT = 3'b011,
        ST_PUSH_A = 3'b010,
        ST_PUSH_B = 3'b110,
        ST_PUSH_S = 3'b111
    } seq_state_t;

endpackage

// File: logic/word_fifo.sv
`timescale 1ns/100ps
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0] count;
    } fifo_state_t;

    fifo_state_t s_r;
    fifo_state_t s_nxt;
    logic push;
    logic pop;

    // Count is one bit wider than the pointers so that full and empty stay distinct
    assign in_ready_out = (s_r.count != (PW + 1)'(DEPTH));
    assign out_valid_out = (s_r.count != '0);
    assign out_data_out = s_r.mem[s_r.rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wr_ptr] = in_data_in;
            s_nxt.wr_ptr = (s_r.wr_ptr == PW'(DEPTH - 1)) ? '0 : s_r.wr_ptr + 1'b1;
        end
        if (pop) begin
            s_nxt.rd_ptr = (s_r.rd_ptr == PW'(DEPTH - 1)) ? '0 : s_r.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            s_nxt.count = s_r.count + 1'b1;
        end else if (pop && !push) begin
            s_nxt.count = s_r.count - 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule // word_fifo

// File: logic/adc_sequencer.sv
// Summary of operation
// - Stack layers 0..23 at indices 0x28..0x3F, end flag and select fields reset to zero.
// - Bits 15:9 of each layer word carry its own address; host writes it there.
// - End flag clear: move to next layer after converting the pair; layer 23 wraps as if its flag were set.
// - End flag set: last layer; then wrap to first layer and continue.
// - B select codes 0-7 inputs, 8 supply, 9 regulator, 10 and 12-15 reserved.
// - Code 1011 gives self-test results 0xAAAA on A and 0x5555 on B.
// - A select field in bits 3:0 uses the same code table as B.
// - Sixteen-bit status word, readable, never writable.
// - Status or CRC enable appends status word after last result word.
// - Status bits 15:12 hold channel index of previous A result.
// - Status bits 11:8 hold channel index of previous B result.
// - Status low byte holds CRC-8 over the previous results.
`timescale 1ns/100ps
module adc_sequencer (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire adc_seq_pkg::apb_req_t apb_in,
    output adc_seq_pkg::apb_rsp_t apb_out,
    output adc_seq_pkg::conv_ctrl_t conv_out,
    input wire adc_seq_pkg::conv_result_t conv_in,
    output logic result_valid_out,
    input wire logic result_ready_in,
    output logic [15:0] result_data_out,
    output logic busy_out
);
    import adc_seq_pkg::*;

    typedef struct packed {
        layer_t [STACK_DEPTH-1:0] layers;
        logic run;
        logic stat_en;
        logic crc_en;
        seq_state_t state;
        logic [LAYER_W-1:0] layer;
        logic [3:0] a_sel;
        logic [3:0] b_sel;
        logic start;
        logic [15:0] res_a;
        logic [15:0] res_b;
        logic [7:0] crc;
        logic [15:0] status;
    } seq_t;

    seq_t s_r;
    seq_t s_nxt;

    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [15:0] fifo_in_data;

    logic [6:0] idx;
    logic addr_aligned;
    logic is_stack;
    logic is_ctrl;
    logic is_status;
    logic mapped;
    logic acc;
    logic wr_ok;
    logic [LAYER_W-1:0] slot;
    layer_t cur;

    // Index is valid when the byte address is word aligned and in range
    function automatic logic stack_hit(input logic [6:0] i);
        return (i >= STACK_FIRST_IDX) && (i <= STACK_LAST_IDX);
    endfunction

    function automatic logic [LAYER_W-1:0] stack_slot(input logic [6:0] i);
        logic [6:0] d;
        d = i - STACK_FIRST_IDX;
        return d[LAYER_W-1:0];
    endfunction

    function automatic logic [7:0] crc_word(input logic [7:0] c, input logic [15:0] w);
        logic [7:0] r;
        r = c;
        for (int k = 15; k >= 0; k--) begin
            if (r[7] ^ w[k]) begin
                r = {r[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                r = {r[6:0], 1'b0};
            end
        end
        return r;
    endfunction

    // Self test substitutes fixed patterns for the converter codes
    function automatic logic [15:0] pick_code(input logic [3:0] sel, input logic [15:0] code,
                                              input logic [15:0] pattern);
        return (sel == SEL_SELF_TEST) ? pattern : code;
    endfunction

    assign idx = apb_in.paddr[8:2];
    assign addr_aligned = (apb_in.paddr[1:0] == 2'b00) && !apb_in.paddr[9];
    assign is_stack = addr_aligned && stack_hit(idx);
    assign is_ctrl = addr_aligned && (idx == CTRL_IDX);
    assign is_status = addr_aligned && (idx == STATUS_IDX);
    assign mapped = is_stack || is_ctrl || is_status;
    assign acc = apb_in.psel && apb_in.penable;
    assign slot = stack_slot(idx);
    assign cur = s_r.layers[s_r.layer];

    // Writes to a layer must carry the layer's own address in the top field
    always_comb begin
        wr_ok = 1'b0;
        if (is_stack) begin
            wr_ok = (apb_in.pwdata[ADDR_MSB:ADDR_LSB] == idx);
        end else if (is_ctrl) begin
            wr_ok = 1'b1;
        end
    end

    always_comb begin
        apb_out.pready = 1'b1;
        apb_out.pslverr = 1'b0;
        apb_out.prdata = 32'h0000_0000;
        if (acc) begin
            if (!mapped) begin
                apb_out.pslverr = 1'b1;
            end else if (apb_in.pwrite && !wr_ok) begin
                apb_out.pslverr = 1'b1;
            end
        end
        if (is_stack) begin
            apb_out.prdata[ADDR_MSB:ADDR_LSB] = idx;
            apb_out.prdata[END_BIT] = s_r.layers[slot].end_flag;
            apb_out.prdata[BSEL_MSB:BSEL_LSB] = s_r.layers[slot].b_sel;
            apb_out.prdata[ASEL_MSB:ASEL_LSB] = s_r.layers[slot].a_sel;
        end else if (is_ctrl) begin
            apb_out.prdata[CTRL_RUN_BIT] = s_r.run;
            apb_out.prdata[CTRL_STAT_BIT] = s_r.stat_en;
            apb_out.prdata[CTRL_CRC_BIT] = s_r.crc_en;
            apb_out.prdata[CTRL_LAYER_MSB:CTRL_LAYER_LSB] = s_r.layer;
        end else if (is_status) begin
            apb_out.prdata[15:0] = s_r.status;
        end
    end

    always_comb begin
        fifo_in_valid = 1'b0;
        fifo_in_data = s_r.res_a;
        case (s_r.state)
            ST_PUSH_A: begin
                fifo_in_valid = 1'b1;
                fifo_in_data = s_r.res_a;
            end
            ST_PUSH_B: begin
                fifo_in_valid = 1'b1;
                fifo_in_data = s_r.res_b;
            end
            ST_PUSH_S: begin
                fifo_in_valid = 1'b1;
                fifo_in_data = s_r.status;
            end
            default: begin
                fifo_in_valid = 1'b0;
            end
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.start = 1'b0;

        if (acc && apb_in.pwrite && wr_ok) begin
            if (is_stack) begin
                s_nxt.layers[slot].end_flag = apb_in.pwdata[END_BIT];
                s_nxt.layers[slot].b_sel = apb_in.pwdata[BSEL_MSB:BSEL_LSB];
                s_nxt.layers[slot].a_sel = apb_in.pwdata[ASEL_MSB:ASEL_LSB];
            end else begin
                s_nxt.run = apb_in.pwdata[CTRL_RUN_BIT];
                s_nxt.stat_en = apb_in.pwdata[CTRL_STAT_BIT];
                s_nxt.crc_en = apb_in.pwdata[CTRL_CRC_BIT];
            end
        end

        case (s_r.state)
            ST_IDLE: begin
                if (s_r.run) begin
                    s_nxt.state = ST_CONV;
                end
            end
            ST_CONV: begin
                // Select codes pass straight to the mux, reserved ones included
                s_nxt.a_sel = cur.a_sel;
                s_nxt.b_sel = cur.b_sel;
                s_nxt.start = 1'b1;
                s_nxt.state = ST_WAIT;
            end
            ST_WAIT: begin
                if (conv_in.done) begin
                    s_nxt.res_a = pick_code(s_r.a_sel, conv_in.a_code, SELF_TEST_A);
                    s_nxt.res_b = pick_code(s_r.b_sel, conv_in.b_code, SELF_TEST_B);
                    s_nxt.state = ST_PUSH_A;
                end
            end
            ST_PUSH_A: begin
                if (fifo_in_ready) begin
                    s_nxt.crc = crc_word(s_r.crc, s_r.res_a);
                    s_nxt.state = ST_PUSH_B;
                end
            end
            ST_PUSH_B: begin
                if (fifo_in_ready) begin
                    s_nxt.crc = crc_word(s_r.crc, s_r.res_b);
                    s_nxt.status[15:12] = s_r.a_sel;
                    s_nxt.status[11:8] = s_r.b_sel;
                    s_nxt.status[7:0] = crc_word(s_r.crc, s_r.res_b);
                    if (cur.end_flag || (s_r.layer == LAYER_LAST)) begin
                        if (s_r.stat_en || s_r.crc_en) begin
                            s_nxt.state = ST_PUSH_S;
                        end else begin
                            s_nxt.layer = LAYER_FIRST;
                            s_nxt.crc = CRC_INIT;
                            s_nxt.state = s_r.run ? ST_CONV : ST_IDLE;
                        end
                    end else begin
                        s_nxt.layer = LAYER_W'(s_r.layer + 1'b1);
                        s_nxt.state = s_r.run ? ST_CONV : ST_IDLE;
                    end
                end
            end
            ST_PUSH_S: begin
                if (fifo_in_ready) begin
                    s_nxt.layer = LAYER_FIRST;
                    s_nxt.crc = CRC_INIT;
                    s_nxt.state = s_r.run ? ST_CONV : ST_IDLE;
                end
            end
            default: begin
                s_nxt.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            s_r.layers <= {STACK_DEPTH{LAYER_RESET}};
            s_r.run <= 1'b0;
            s_r.stat_en <= 1'b0;
            s_r.crc_en <= 1'b0;
            s_r.state <= ST_IDLE;
            s_r.layer <= LAYER_FIRST;
            s_r.a_sel <= 4'h0;
            s_r.b_sel <= 4'h0;
            s_r.start <= 1'b0;
            s_r.res_a <= 16'h0000;
            s_r.res_b <= 16'h0000;
            s_r.crc <= CRC_INIT;
            s_r.status <= 16'h0000;
        end else begin
            s_r <= s_nxt;
        end
    end

    word_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(fifo_in_valid),
        .in_ready_out(fifo_in_ready),
        .in_data_in(fifo_in_data),
        .out_valid_out(result_valid_out),
        .out_ready_in(result_ready_in),
        .out_data_out(result_data_out)
    );

    assign conv_out.a_sel = s_r.a_sel;
    assign conv_out.b_sel = s_r.b_sel;
    assign conv_out.start = s_r.start;
    assign busy_out = (s_r.state != ST_IDLE);

endmodule // adc_sequencer

// File: testbench/adc_sequencer_sva.sv
`timescale 1ns/100ps
module adc_sequencer_sva (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire adc_seq_pkg::apb_req_t apb_in,
    input wire adc_seq_pkg::apb_rsp_t apb_out,
    input wire adc_seq_pkg::conv_ctrl_t conv_out,
    input wire adc_seq_pkg::conv_result_t conv_in,
    input wire logic result_valid_out,
    input wire logic result_ready_in,
    input wire logic [15:0] result_data_out,
    input wire logic busy_out
);
    import adc_seq_pkg::*;
    logic acc;
    logic stk;
    logic [7:0] idx;
    assign acc = apb_in.psel && apb_in.penable;
    assign idx = apb_in.paddr[9:2];
    assign stk = apb_in.paddr[1:0] == 2'h0 && idx >= {1'b0, STACK_FIRST_IDX}
        && idx <= {1'b0, STACK_LAST_IDX};
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    start_pulse_a: assert property (conv_out.start |-> busy_out ##1 !conv_out.start)
        else $error("start pulse too long");
    run_start_a: assert property ($rose(busy_out) |-> ##[0:2] conv_out.start)
        else $error("no start after run");
    bad_align_a: assert property (acc && apb_in.paddr[1:0] != 2'h0 |-> apb_out.pslverr
        && apb_out.prdata == 32'h0) else $error("misaligned access taken");
    status_ro_a: assert property (acc && apb_in.pwrite && idx == {1'b0, STATUS_IDX}
        |-> apb_out.pslverr) else $error("status write accepted");
    addr_field_a: assert property (acc && apb_in.pwrite && stk
        && apb_in.pwdata[15:9] != apb_in.paddr[8:2] |-> apb_out.pslverr)
        else $error("wrong address field accepted");
    layer_read_a: assert property (acc && !apb_in.pwrite && stk |-> !apb_out.pslverr
        && apb_out.prdata[31:9] == {16'h0, apb_in.paddr[8:2]}) else $error("layer read bad");
    status_read_a: assert property (acc && !apb_in.pwrite && idx == {1'b0, STATUS_IDX}
        |-> !apb_out.pslverr && apb_out.prdata[31:16] == 16'h0) else $error("status read bad");
    reset_idle_a: assert property ($rose(rst_n_in) |-> !result_valid_out && !busy_out
        && !conv_out.start) else $error("not idle after reset");
    head_hold_a: assert property (result_valid_out && !result_ready_in |=> result_valid_out
        && $stable(result_data_out)) else $error("head word lost");
    cover property (conv_out.start);
    cover property (result_valid_out && result_ready_in && result_data_out == SELF_TEST_A);
    cover property (acc && apb_out.pslverr);
endmodule // adc_sequencer_sva

bind adc_sequencer adc_sequencer_sva adc_sequencer_sva_inst (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .apb_in(apb_in), .apb_out(apb_out), .conv_out(conv_out),
    .conv_in(conv_in), .result_valid_out(result_valid_out), .result_ready_in(result_ready_in),
    .result_data_out(result_data_out), .busy_out(busy_out));

// File: testbench/conv_model.sv
`timescale 1ns/100ps
module conv_model (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire adc_seq_pkg::conv_ctrl_t ctrl_in,
    output adc_seq_pkg::conv_result_t res_out
);
    import adc_seq_pkg::*;
    int wait_cnt = 0;
    logic [7:0] n;
    logic [3:0] a;
    logic [3:0] b;
    initial res_out = '0;
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            wait_cnt <= 0;
            n <= 8'h00;
            res_out <= '0;
        end else if (ctrl_in.start) begin
            wait_cnt <= 1 + $urandom % 5;
            a <= ctrl_in.a_sel;
            b <= ctrl_in.b_sel;
            res_out.done <= 1'b0;
        end else if (wait_cnt == 1) begin
            wait_cnt <= 0;
            n <= n + 8'h01;
            // Codes carry the selects so a wrong decode shows up in the words
            res_out <= '{done: 1'b1, a_code: {4'h1, a, n}, b_code: {4'h2, b, n}};
        end else begin
            if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
            res_out <= '{done: 1'b0, a_code: ~res_out.a_code, b_code: ~res_out.b_code};
        end
    end
endmodule // conv_model

// File: testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
    import adc_seq_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    conv_ctrl_t cctl;
    conv_result_t cres;
    logic rvalid;
    logic rready = 1'b0;
    logic busy;
    logic [15:0] rdata;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [3:0] asel [24];
    logic [3:0] bsel [24];
    int len, slot, phase, nconv, stat;
    logic [7:0] crc;
    logic [31:0] rd;
    logic [31:0] wd;
    logic err;

    adc_sequencer adc_sequencer_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .apb_in(req),
        .apb_out(rsp), .conv_out(cctl), .conv_in(cres), .result_valid_out(rvalid),
        .result_ready_in(rready), .result_data_out(rdata), .busy_out(busy));
    conv_model conv_model_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ctrl_in(cctl),
        .res_out(cres));

    always #25 mclk_in = ~mclk_in;

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
        req.paddr <= a;
        req.pwrite <= wr;
        req.pwdata <= d;
        req.psel <= 1'b1;
        @(posedge mclk_in);
        req.penable <= 1'b1;
        @(posedge mclk_in);
        while (rsp.pready !== 1'b1) @(posedge mclk_in);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge mclk_in);
    endtask

    function automatic logic [7:0] crc_upd(input logic [7:0] c, input logic [15:0] d);
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
        return c;
    endfunction

    // Legal select codes only: 0..9 and self test
    function automatic logic [3:0] pick();
        int r;
        r = $urandom % 11;
        return (r == 10) ? SEL_SELF_TEST : 4'(r);
    endfunction

    task automatic next_exp(output logic [15:0] w);
        if (phase == 0) w = (asel[slot] == SEL_SELF_TEST) ? SELF_TEST_A : {4'h1, asel[slot], 8'(nconv)};
        else if (phase == 1) w = (bsel[slot] == SEL_SELF_TEST) ? SELF_TEST_B : {4'h2, bsel[slot], 8'(nconv)};
        else w = {asel[len - 1], bsel[len - 1], crc};
        if (phase < 2) crc = crc_upd(crc, w);
        if (phase == 1) nconv++;
        if (phase == 0) phase = 1;
        else if (phase == 1 && slot < len - 1) begin
            phase = 0;
            slot++;
        end else if (phase == 1 && stat != 0) phase = 2;
        else begin
            phase = 0;
            slot = 0;
            crc = CRC_INIT;
        end
    endtask

    task automatic drain(input int n, input bit idle);
        logic [15:0] w;
        while (n > 0 || (idle && (busy !== 1'b0 || rvalid !== 1'b0))) begin
            @(posedge mclk_in);
            if (rvalid === 1'b1 && rready === 1'b1) begin
                next_exp(w);
                check(rdata, w);
                n--;
            end
            rready <= (n > 0 || idle) ? 1'($urandom % 2) : 1'b0;
        end
    endtask

    initial begin
        int modes [3] = '{1, 3, 5};
        void'($urandom(81293));
        foreach (modes[m]) begin
            rst_n_in <= 1'b0;
            repeat (3) @(posedge mclk_in);
            rst_n_in <= 1'b1;
            @(posedge mclk_in);
            for (int i = 0; i < 24; i++) begin
                apb(1'b0, 10'(4 * i + 160), 32'h0);
                check(rd, {16'h0, 7'(i + 40), 9'h000});
            end
            apb(1'b0, 10'h104, 32'h0);
            check(rd, 32'h0);
            len = 2 + $urandom % 4;
            for (int i = 0; i < 24; i++) begin
                asel[i] = (i == 0) ? SEL_SELF_TEST : (i == 1) ? SEL_SUPPLY : pick();
                bsel[i] = (i == 1) ? SEL_SELF_TEST : (i == 0) ? SEL_REGULATOR : pick();
                wd = {16'h0, 7'(i + 40), 1'(i == len - 1), bsel[i], asel[i]};
                apb(1'b1, 10'(4 * i + 160), wd);
                check(err, 1'b0);
                apb(1'b0, 10'(4 * i + 160), 32'h0);
                check(rd, wd);
            end
            apb(1'b1, 10'h0A8, {16'h0, 7'h2B, 9'h1FF});
            check(err, 1'b1);
            apb(1'b0, 10'h0A8, 32'h0);
            check(rd, {16'h0, 7'h2A, 1'(len == 3), bsel[2], asel[2]});
            apb(1'b1, 10'h104, 32'hFFFF);
            check(err, 1'b1);
            apb(1'b0, 10'h200, 32'h0);
            check({err, rd[30:0]}, 32'h80000000);
            apb(1'b1, 10'h0A1, {16'h0, 7'h28, 9'h000});
            check(err, 1'b1);
            apb(1'b0, 10'h0A0, 32'h0);
            check(rd, {16'h0, 7'h28, 1'b0, bsel[0], asel[0]});
            apb(1'b1, 10'h100, 32'(modes[m]));
            slot = 0;
            phase = 0;
            nconv = 0;
            crc = CRC_INIT;
            stat = modes[m] > 1;
            repeat (150) @(posedge mclk_in);
            drain(6 * len, 1'b0);
            apb(1'b1, 10'h100, 32'(modes[m] - 1));
            drain(0, 1'b1);
        end
        report_and_stop();
    end
endmodule // testbench
